// ==== logic/cpu_bus_handover_sync.sv ====
// Purpose: sync-input pause, handoff-op publishing, two-line bus lending
// Assumes: all inputs but rst synchronous to sys_clk; max_mode strap stable at reset
// Notes:   request/grant pins are split into in, out and output-enable (low = drive)
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_handover_sync
  import cpu_bus_handover_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                max_mode,
  input  wire logic                wait_exec,
  input  wire logic                sync_in_n,
  output logic                     wait_idle,
  output logic                     wait_done,
  input  wire logic                op_fetch,
  input  wire logic                op_is_handoff,
  input  wire logic [5:0]          op_field,
  output handoff_bus_t             coprocessor_handoff_op,
  input  wire logic                q_first,
  input  wire logic                q_flush,
  input  wire logic                q_next,
  output queue_status_t            queue_status,
  input  wire logic                locked_instr,
  input  wire logic                hold_req,
  output logic                     bus_takeover_ack,
  input  wire logic [RG_LINES-1:0] req_grant_in_n,
  output logic [RG_LINES-1:0]      req_grant_out_n,
  output logic [RG_LINES-1:0]      req_grant_oe_n,
  input  wire logic                exec_needs_bus,
  input  wire logic                queue_empty,
  output logic                     bus_interface_unit_off,
  output logic                     execution_unit_stall
);

  // ==========================================================
  // strap capture
  // caught after release so the async reset only loads a constant
  logic max_q;
  logic strap_done_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      max_q        <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      max_q        <= max_mode;
      strap_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // pause until sync input
  wait_state_t wstate_q;
  logic [2:0]  retest_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wstate_q  <= W_RUN;
      retest_q  <= RETEST_ZERO;
      wait_done <= 1'b0;
    end else begin
      wait_done <= 1'b0;
      case (wstate_q)
        W_RUN: begin
          retest_q <= RETEST_ZERO;
          if (wait_exec && !sync_in_n) begin
            wait_done <= 1'b1;
          end else if (wait_exec) begin
            wstate_q <= W_IDLE;
          end
        end
        W_IDLE: begin
          if (retest_q == RETEST_LAST) begin
            retest_q <= RETEST_ZERO;
            if (!sync_in_n) begin
              wstate_q  <= W_RUN;
              wait_done <= 1'b1;
            end
          end else begin
            retest_q <= retest_q + RETEST_STEP;
          end
        end
        default: begin
          wstate_q <= W_RUN;
          retest_q <= RETEST_ZERO;
        end
      endcase
    end
  end

  assign wait_idle = (wstate_q == W_IDLE);

  // ==========================================================
  // handoff op and queue status
  // publish fetched handoff field
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coprocessor_handoff_op.valid <= 1'b0;
      coprocessor_handoff_op.field <= HANDOFF_FIELD_RST;
    end else begin
      coprocessor_handoff_op.valid <= op_fetch && op_is_handoff;
      if (op_fetch && op_is_handoff) begin
        coprocessor_handoff_op.field <= op_field;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      queue_status <= QS_NONE;
    end else if (q_flush) begin
      queue_status <= QS_FLUSH;
    end else if (q_first) begin
      queue_status <= QS_FIRST;
    end else if (q_next) begin
      queue_status <= QS_NEXT;
    end else begin
      queue_status <= QS_NONE;
    end
  end

  // ==========================================================
  // request/grant lending
  loan_state_t         lstate_q;
  logic                owner_q;
  logic [RG_LINES-1:0] pend_q;
  logic [RG_LINES-1:0] pulse_seen;
  logic [RG_LINES-1:0] req_set;
  logic [RG_LINES-1:0] req_clr;
  logic                grant_go;
  logic                grant_sel;
  logic                release_seen;

  genvar gi;
  generate
    for (gi = 0; gi < RG_LINES; gi++) begin : g_line
      // low pulse while line not driven by us
      assign pulse_seen[gi] = max_q && !req_grant_in_n[gi] && req_grant_oe_n[gi];
      // owner's pulse during its loan is a release, not a request
      assign req_set[gi]    = pulse_seen[gi] &&
                              !((lstate_q != L_IDLE) && (owner_q == 1'(gi)));
      assign req_clr[gi]    = grant_go && (grant_sel == 1'(gi));
      assign req_grant_out_n[gi] = 1'b0;
    end
  endgenerate

  assign grant_go     = (lstate_q == L_IDLE) && (pend_q != RG_NONE) && !locked_instr;
  assign grant_sel    = pend_q[RG_HI] ? 1'b0 : 1'b1;
  assign release_seen = (lstate_q == L_LOAN) && pulse_seen[owner_q];

  // set wins over clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_q <= RG_NONE;
    end else begin
      pend_q <= (pend_q & ~req_clr) | req_set;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lstate_q       <= L_IDLE;
      owner_q        <= 1'b0;
      req_grant_oe_n <= RG_IDLE_N;
    end else begin
      req_grant_oe_n <= RG_IDLE_N;
      case (lstate_q)
        L_IDLE: begin
          if (grant_go) begin
            lstate_q                  <= L_GRANT;
            owner_q                   <= grant_sel;
            req_grant_oe_n[grant_sel] <= 1'b0;
          end
        end
        L_GRANT: lstate_q <= L_LOAN;
        L_LOAN: begin
          if (release_seen) begin
            lstate_q <= L_IDLE;
          end
        end
        default: lstate_q <= L_IDLE;
      endcase
    end
  end

  // minimum mode takeover pair, held off by a locked instruction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_takeover_ack <= 1'b0;
    end else if (max_q || !hold_req) begin
      bus_takeover_ack <= 1'b0;
    end else if (!locked_instr) begin
      bus_takeover_ack <= 1'b1;
    end
  end

  assign bus_interface_unit_off = (lstate_q != L_IDLE) || bus_takeover_ack;
  assign execution_unit_stall   = bus_interface_unit_off && (exec_needs_bus || queue_empty);

  // ==========================================================
  // assertions
  property p_wait_direct;
    @(posedge sys_clk) disable iff (rst)
      (wstate_q == W_RUN && wait_exec && !sync_in_n) |=> (wait_done && !wait_idle);
  endproperty
  a_wait_direct: assert property (p_wait_direct) else $error("direct pass failed");

  property p_wait_hold;
    @(posedge sys_clk) disable iff (rst)
      $rose(wait_idle) |-> (wait_idle && !wait_done) [*5];
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("retest interval short");

  property p_wait_exit;
    @(posedge sys_clk) disable iff (rst)
      (wait_idle && !sync_in_n) |-> ##[1:5] wait_done;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("idle did not end");

  property p_handoff;
    @(posedge sys_clk) disable iff (rst)
      (op_fetch && op_is_handoff) |=>
        (coprocessor_handoff_op.valid && coprocessor_handoff_op.field == $past(op_field));
  endproperty
  a_handoff: assert property (p_handoff) else $error("handoff field lost");

  property p_flush_code;
    @(posedge sys_clk) disable iff (rst)
      q_flush |=> (queue_status == QS_FLUSH);
  endproperty
  a_flush_code: assert property (p_flush_code) else $error("flush not reported");

  property p_prio;
    @(posedge sys_clk) disable iff (rst)
      (lstate_q == L_IDLE && pend_q == RG_IDLE_N && !locked_instr) |=>
        (!req_grant_oe_n[RG_HI] && req_grant_oe_n[RG_LO]);
  endproperty
  a_prio: assert property (p_prio) else $error("line 1 granted first");

  property p_no_preempt;
    @(posedge sys_clk) disable iff (rst)
      (lstate_q == L_LOAN && owner_q && !release_seen) |=> req_grant_oe_n[RG_HI];
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("loan preempted");

  property p_lock;
    @(posedge sys_clk) disable iff (rst)
      (locked_instr && lstate_q == L_IDLE) |=> (req_grant_oe_n == RG_IDLE_N);
  endproperty
  a_lock: assert property (p_lock) else $error("grant during lock");

  property p_pulse_width;
    @(posedge sys_clk) disable iff (rst)
      (req_grant_oe_n != RG_IDLE_N) |=> (req_grant_oe_n == RG_IDLE_N) ##0 (lstate_q == L_LOAN);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("grant pulse width");

  property p_min_mode;
    @(posedge sys_clk) disable iff (rst)
      (!max_q) |-> (req_grant_oe_n == RG_IDLE_N && lstate_q == L_IDLE);
  endproperty
  a_min_mode: assert property (p_min_mode) else $error("lines active in min mode");

  property p_loan_off;
    @(posedge sys_clk) disable iff (rst)
      (lstate_q == L_LOAN) |-> (bus_interface_unit_off &&
        (execution_unit_stall == (exec_needs_bus || queue_empty)));
  endproperty
  a_loan_off: assert property (p_loan_off) else $error("bus not released");

  property p_release;
    @(posedge sys_clk) disable iff (rst)
      release_seen |=> (lstate_q == L_IDLE); 
  endproperty
  a_release: assert property (p_release) else $error("release ignored");

  c_wait_idle: cover property (@(posedge sys_clk) disable iff (rst) $fell(wait_idle));
  c_both_req: cover property (@(posedge sys_clk) disable iff (rst) pend_q == RG_IDLE_N);
  c_loan_done: cover property (@(posedge sys_clk) disable iff (rst) release_seen);

endmodule

`default_nettype wire

// ==== logic/cpu_bus_handover_pkg.sv ====
// Purpose: shared constants and types for the bus handover and sync block
// Assumes: everything runs on sys_clk at 25 MHz
// Notes:   request/grant pulses are one clock wide and active low
package cpu_bus_handover_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned SYNC_RETEST_CLK = 5;
  localparam logic [2:0]  RETEST_LAST     = 3'(SYNC_RETEST_CLK - 1);
  localparam logic [2:0]  RETEST_ZERO     = 3'h0;
  localparam logic [2:0]  RETEST_STEP     = 3'h1;

  // ==========================================================
  // request/grant lines
  localparam int unsigned RG_LINES  = 2;
  localparam int unsigned RG_HI     = 0;
  localparam int unsigned RG_LO     = 1;
  localparam logic [1:0]  RG_IDLE_N = 2'h3;
  localparam logic [1:0]  RG_NONE   = 2'h0;

  // ==========================================================
  // queue status codes
  localparam logic [1:0] QS_NONE  = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_FLUSH = 2'h2;
  localparam logic [1:0] QS_NEXT  = 2'h3;

  localparam logic [5:0] HANDOFF_FIELD_RST = 6'h00;

  // ==========================================================
  // states
  typedef enum logic [1:0] {
    W_RUN  = 2'b01,
    W_IDLE = 2'b10
  } wait_state_t;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b001,
    L_GRANT = 3'b010,
    L_LOAN  = 3'b100
  } loan_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic queue_status_bit1;
    logic queue_status_bit0;
  } queue_status_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] field;
  } handoff_bus_t;

endpackage

// ==== test/rg_requester.sv ====
// Purpose: model of one outside bus master on a request/grant line
// Assumes: shares sys_clk with the device; line has a pull-up
// Notes:   holds the bus loan_len+1 clocks after it sees the grant, then hands it back
`timescale 1ns/1ps
`default_nettype none

module rg_requester (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       line_n,
  input  wire logic       start,
  input  wire logic [3:0] loan_len,
  output logic            pull_low,
  output logic            on_loan
);
  logic [1:0] st_q;
  logic [3:0] cnt_q;

  // ==========================================================
  // handshake
  // one-clock low pulses
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q     <= 2'h0;
      cnt_q    <= 4'h0;
      pull_low <= 1'b0;
      on_loan  <= 1'b0;
    end else begin
      // request pulse from idle, release pulse at loan end, one write per edge
      pull_low <= #1 ((st_q == 2'h0) && start) || ((st_q == 2'h2) && (cnt_q == 4'h0));
      case (st_q)
        2'h0: if (start) begin
          st_q     <= #1 2'h1;
        end
        // own pulse must not be mistaken for the grant
        2'h1: if (!line_n && !pull_low) begin
          st_q    <= #1 2'h2;
          cnt_q   <= #1 loan_len;
          on_loan <= #1 1'b1;
        end
        2'h2: if (cnt_q == 4'h0) begin
          on_loan  <= #1 1'b0;
          st_q     <= #1 2'h0;
        end else begin
          cnt_q <= #1 cnt_q - 4'h1;
        end
        default: st_q <= #1 2'h0;
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== test/test_cpu_bus_handover_sync.sv ====
// Purpose: self-checking bench for the bus handover and sync block
// Assumes: two requester models on the request/grant lines
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t %s", $time, m); end end

module test_cpu_bus_handover_sync;
  import cpu_bus_handover_pkg::*;
  localparam logic [2:0] EV [6] = '{3'h4, 3'h2, 3'h1, 3'h6, 3'h5, 3'h0};
  localparam logic [1:0] QX [6] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0};
  logic          sys_clk, rst, max_mode, wait_exec, sync_in_n, op_fetch, op_is_handoff;
  logic          q_first, q_flush, q_next, locked_instr, hold_req, exec_needs_bus, queue_empty;
  logic          wait_idle, wait_done, ack, unit_off, stall, prev_off;
  logic [5:0]    op_field;
  logic [3:0]    loan_len;
  logic [1:0]    start, pull, oe_n, out_n, line_n, prev_oe, on_loan;
  handoff_bus_t  hop;
  queue_status_t qs;
  int            n_fail, n_compared, cyc, n;

  // open-drain wire with pull-up
  assign line_n = ~((~oe_n & ~out_n) | pull);

  cpu_bus_handover_sync u_dut (.sys_clk(sys_clk), .rst(rst), .max_mode(max_mode),
    .wait_exec(wait_exec), .sync_in_n(sync_in_n), .wait_idle(wait_idle),
    .wait_done(wait_done), .op_fetch(op_fetch), .op_is_handoff(op_is_handoff),
    .op_field(op_field), .coprocessor_handoff_op(hop), .q_first(q_first),
    .q_flush(q_flush), .q_next(q_next), .queue_status(qs), .locked_instr(locked_instr),
    .hold_req(hold_req), .bus_takeover_ack(ack), .req_grant_in_n(line_n),
    .req_grant_out_n(out_n), .req_grant_oe_n(oe_n), .exec_needs_bus(exec_needs_bus),
    .queue_empty(queue_empty), .bus_interface_unit_off(unit_off),
    .execution_unit_stall(stall));
  rg_requester u_req0 (.sys_clk(sys_clk), .rst(rst), .line_n(line_n[0]), .start(start[0]),
    .loan_len(loan_len), .pull_low(pull[0]), .on_loan(on_loan[0]));
  rg_requester u_req1 (.sys_clk(sys_clk), .rst(rst), .line_n(line_n[1]), .start(start[1]),
    .loan_len(loan_len), .pull_low(pull[1]), .on_loan(on_loan[1]));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task results;
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // line monitor and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (!rst) begin
      `CHK(~oe_n & ~prev_oe, 2'h0, "grant wider than one clock")
      `CHK(oe_n != 2'h3 && prev_off, 1'b0, "grant during a loan")
    end
    prev_off = unit_off;
    prev_oe = oe_n;
    if (cyc == 4000) begin
      n_fail++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
  end

  // ==========================================================
  // helpers
  task tick;
    @(posedge sys_clk);
    #1;
  endtask

  task do_reset(input logic mm);
    rst = 1'b1;
    max_mode = mm;
    repeat (12) tick();
    `CHK({oe_n, out_n, wait_idle, wait_done, hop, qs, ack, unit_off}, 17'h18000, "reset values")
    rst = 1'b0;
    tick();
    tick();
  endtask

  task req(input logic [1:0] s, input logic [3:0] len);
    loan_len = len;
    start = s;
    tick();
    start = 2'h0;
  endtask

  task wait_grant(input int i, input int lim);
    n = 0;
    while (oe_n[i] !== 1'b0 && n < lim) begin
      tick();
      n++;
    end
  endtask

  task wait_free;
    n = 0;
    while (unit_off !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    `CHK(unit_off, 1'b0, "bus not returned")
  endtask

  // ==========================================================
  // scenarios
  task t_pause(input logic early);
    wait_exec = 1'b1;
    sync_in_n = ~early;
    tick();
    wait_exec = 1'b0;
    n = 1;
    `CHK(wait_idle, ~early, "idle entry")
    while (wait_done !== 1'b1 && n < 30) begin
      if (n == 2) sync_in_n = 1'b0;
      tick();
      n++;
    end
    `CHK(n, early ? 1 : 6, "pause length")
    tick();
    `CHK({wait_done, wait_idle}, 2'h0, "pause end")
    sync_in_n = 1'b1;
  endtask

  task t_handoff;
    op_fetch = 1'b1;
    op_is_handoff = 1'b1;
    op_field = 6'h3f;
    tick();
    op_is_handoff = 1'b0;
    op_field = 6'h15;
    `CHK(hop, 7'h7f, "handoff capture")
    tick();
    op_fetch = 1'b0;
    `CHK(hop, 7'h3f, "plain fetch")
  endtask

  task t_queue;
    int k;
    for (k = 0; k < 6; k++) begin
      {q_first, q_flush, q_next} = EV[k];
      tick();
      `CHK(qs, QX[k], "queue status")
    end
  endtask

  task t_single;
    req(2'h1, 4'h5);
    wait_grant(0, 20);
    `CHK(n, 2, "grant latency")
    exec_needs_bus = 1'b0;
    queue_empty = 1'b0;
    #1;
    `CHK({unit_off, stall}, 2'h2, "loan runs on")
    tick();
    exec_needs_bus = 1'b1;
    #1;
    `CHK(stall, 1'b1, "stall on bus need")
    {exec_needs_bus, queue_empty} = 2'h1;
    #1;
    `CHK(stall, 1'b1, "stall on empty queue")
    wait_free();
    `CHK(n, 7, "release")
    `CHK(stall, 1'b0, "resume")
    {exec_needs_bus, queue_empty} = 2'h0;
  endtask

  task t_both;
    req(2'h3, 4'h3);
    wait_grant(0, 20);
    `CHK({n, oe_n}, {32'd2, 2'h2}, "line 0 first")
    wait_grant(1, 30);
    `CHK({n > 6 && n < 12, on_loan[0]}, 2'h2, "line 1 after return")
    tick();
    wait_free();
  endtask

  task t_preempt;
    req(2'h2, 4'h6);
    wait_grant(1, 20);
    tick();
    req(2'h1, 4'h2);
    wait_grant(0, 30);
    `CHK({oe_n[0], on_loan[1]}, 2'h0, "no preemption")
    tick();
    wait_free();
  endtask

  task t_locked;
    locked_instr = 1'b1;
    req(2'h1, 4'h2);
    wait_grant(0, 10);
    `CHK(n, 10, "held by lock")
    locked_instr = 1'b0;
    wait_grant(0, 5);
    `CHK(n <= 2 && oe_n[0] === 1'b0, 1'b1, "granted after lock")
    tick();
    wait_free();
  endtask

  task t_min_mode;
    do_reset(1'b0);
    t_pause(1'b0);
    locked_instr = 1'b1;
    hold_req = 1'b1;
    tick();
    `CHK(ack, 1'b0, "ack held by lock")
    locked_instr = 1'b0;
    tick();
    `CHK({ack, unit_off}, 2'h3, "takeover ack")
    hold_req = 1'b0;
    tick();
    `CHK(ack, 1'b0, "ack drop")
    req(2'h1, 4'h2);
    wait_grant(0, 8);
    `CHK(n, 8, "no grant in minimum mode")
  endtask

  initial begin
    {rst, max_mode, wait_exec, sync_in_n, op_fetch, op_is_handoff, q_first} = 7'h48;
    {q_flush, q_next, locked_instr, hold_req, exec_needs_bus, queue_empty} = 6'h0;
    {op_field, loan_len, start} = 12'h0;
    {n_fail, n_compared, cyc} = 0;
    {prev_off, prev_oe} = 3'h3;
    do_reset(1'b1);
    t_pause(1'b0);
    t_pause(1'b1);
    t_handoff();
    t_queue();
    t_single();
    t_both();
    t_preempt();
    t_locked();
    t_min_mode();
    results();
  end
endmodule

`default_nettype wire
